/* File: rtl/bbx_pkg.sv */
//======================================================================
// Overview of operation
// - Opcode E5: branch to PC+2+2n when overflow flag is clear.
// - Opcode E1: branch to PC+2+2n only when zero flag is clear.
// - Opcode E4: branch to PC+2+2n when overflow flag is set.
// - Conditional branch: one cycle untaken; taken writes PC in Q4 plus one idle cycle.
// - Branch offset is signed 8-bit, doubled, added to already incremented PC.
// - Opcode 11010 plus 11-bit offset always branches, two cycles, flags untouched.
// - Bit set: read byte in Q2, write it back with bit b set in Q4.
// - Test-skip-if-clear: skip next instruction when bit b is zero.
// - Test-skip-if-set: skip next instruction when bit b is one.
// - Test-skip: one cycle, two when skipping, three over a two-word instruction.
// - Bit toggle inverts bit b of the byte in one cycle, flags unchanged.
// - Access bit zero selects access bank (FSR2 plus f for f below 60h in extended mode); one selects bank select register.
// - Opcode E7: branch to PC+2+2n when negative flag is clear.
package bbx_pkg;

    //==================================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam logic [1:0] FLUSH_ONE = 2'h1;
    localparam logic [1:0] FLUSH_TWO = 2'h2;

    //==================================================================
    // Opcodes
    localparam logic [7:0] OPC_BR_NO_OVF = 8'hE5;
    localparam logic [7:0] OPC_BR_NOT_ZERO = 8'hE1;
    localparam logic [7:0] OPC_BR_ON_OVF = 8'hE4;
    localparam logic [7:0] OPC_BR_NOT_NEG = 8'hE7;
    localparam logic [4:0] OPC_BR_ALWAYS = 5'h1A;
    localparam logic [3:0] OPC_BIT_SET = 4'h8;
    localparam logic [3:0] OPC_SKIP_CLR = 4'hB;
    localparam logic [3:0] OPC_SKIP_SET = 4'hA;
    localparam logic [3:0] OPC_BIT_TGL = 4'h7;
    localparam logic [3:0] OPC_TWO_WORD_MOVE = 4'hC;
    localparam logic [5:0] OPC_TWO_WORD_LONG = 6'h3B;

    //==================================================================
    // Data memory addressing
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    //==================================================================
    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_BANK_SEL = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_FSR2 = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam logic [7:0] REG_INSTR = 8'h18;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam int STATUS_Z_BIT = 2;
    localparam int STATUS_OV_BIT = 3;
    localparam int STATUS_N_BIT = 4;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [3:0] BANK_SEL_RST = 4'h0;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [11:0] FSR2_RST = 12'h000;

    //==================================================================
    // Types
    typedef enum logic [1:0] {QPH_1, QPH_2, QPH_3, QPH_4} bbx_qphase_e;
    typedef enum logic [3:0] {
        OP_NONE, OP_BR_NO_OVF, OP_BR_NOT_ZERO, OP_BR_ON_OVF, OP_BR_NOT_NEG,
        OP_BR_ALWAYS, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET, OP_BIT_TGL
    } bbx_op_e;
    typedef struct packed {
        logic [11:0] addr;
        logic re;
        logic we;
        logic [7:0] wdata;
    } bbx_dmem_req_s;

endpackage

/* File: rtl/bbx_addr_calc.sv */
module bbx_addr_calc
    import bbx_pkg::*;
(
    // Instruction fields
    input wire logic [7:0] file_addr,
    input wire logic access_bit,
    // Context
    input wire logic [3:0] bank_sel,
    input wire logic ext_en,
    input wire logic [11:0] fsr2,
    // Result
    output logic [11:0] mem_addr
);

    always_comb begin
        if (access_bit) begin
            mem_addr = {bank_sel, file_addr};
        end else if (ext_en && file_addr < ACCESS_SPLIT) begin
            mem_addr = fsr2 + {4'h0, file_addr};
        end else if (file_addr < ACCESS_SPLIT) begin
            mem_addr = {ACCESS_LOW_BANK, file_addr};
        end else begin
            mem_addr = {ACCESS_HIGH_BANK, file_addr};
        end
    end

endmodule

/* File: rtl/bbx_bit_unit.sv */
module bbx_bit_unit
    import bbx_pkg::*;
(
    // Operation
    input wire bbx_op_e op,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] data_in,
    // Results
    output logic [7:0] data_out,
    output logic bit_val
);

    logic [7:0] mask;

    always_comb begin
        mask = 8'h01 << bit_sel;
        bit_val = data_in[bit_sel];
        unique case (op)
            OP_BIT_SET: data_out = data_in | mask;
            OP_BIT_TGL: data_out = data_in ^ mask;
            default: data_out = data_in;
        endcase
    end

endmodule

/* File: rtl/bbx_exec.sv */
module bbx_exec
    import bbx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Program memory
    output logic [20:0] prog_addr,
    input wire logic [15:0] prog_data,
    // Data memory
    output bbx_dmem_req_s dmem_req,
    input wire logic [7:0] dmem_rdata
);

    //==================================================================
    // State
    bbx_qphase_e qph_reg, qph_next;
    bbx_op_e op_reg, op_next, op_dec;
    logic [15:0] instr_reg, instr_next;
    logic [20:0] pc_reg, pc_next;
    logic [7:0] rd_reg, rd_next;
    logic [1:0] flush_reg, flush_next;
    logic flush_adv_reg, flush_adv_next;
    bbx_dmem_req_s dmem_reg, dmem_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [4:0] status_reg, status_next;
    logic [3:0] bank_reg, bank_next;
    logic [11:0] fsr2_reg, fsr2_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;

    logic run;
    logic wr_en;
    logic [31:0] wr_mask;
    logic [31:0] rd_mux;
    logic [11:0] mem_addr;
    logic [7:0] bit_result;
    logic bit_val;
    logic take;
    logic skip;
    logic next_two_word;
    logic [20:0] br_off;
    logic [20:0] br_target;
    logic flag_n;
    logic flag_ov;
    logic flag_z;

    assign run = ctrl_reg[CTRL_RUN_BIT];
    assign flag_n = status_reg[STATUS_N_BIT];
    assign flag_ov = status_reg[STATUS_OV_BIT];
    assign flag_z = status_reg[STATUS_Z_BIT];
    assign prog_addr = pc_reg;
    assign dmem_req = dmem_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    //==================================================================
    // Helpers
    bbx_addr_calc u_addr (
        .file_addr(instr_next[7:0]),
        .access_bit(instr_next[8]),
        .bank_sel(bank_reg),
        .ext_en(ctrl_reg[CTRL_EXT_BIT]),
        .fsr2(fsr2_reg),
        .mem_addr(mem_addr)
    );

    bbx_bit_unit u_bit (
        .op(op_reg),
        .bit_sel(instr_reg[11:9]),
        .data_in(rd_reg),
        .data_out(bit_result),
        .bit_val(bit_val)
    );

    //==================================================================
    // Decode of the word on the program bus
    always_comb begin
        if (prog_data[15:8] == OPC_BR_NO_OVF) begin
            op_dec = OP_BR_NO_OVF;
        end else if (prog_data[15:8] == OPC_BR_NOT_ZERO) begin
            op_dec = OP_BR_NOT_ZERO;
        end else if (prog_data[15:8] == OPC_BR_ON_OVF) begin
            op_dec = OP_BR_ON_OVF;
        end else if (prog_data[15:8] == OPC_BR_NOT_NEG) begin
            op_dec = OP_BR_NOT_NEG;
        end else if (prog_data[15:11] == OPC_BR_ALWAYS) begin
            op_dec = OP_BR_ALWAYS;
        end else if (prog_data[15:12] == OPC_BIT_SET) begin
            op_dec = OP_BIT_SET;
        end else if (prog_data[15:12] == OPC_SKIP_CLR) begin
            op_dec = OP_SKIP_CLR;
        end else if (prog_data[15:12] == OPC_SKIP_SET) begin
            op_dec = OP_SKIP_SET;
        end else if (prog_data[15:12] == OPC_BIT_TGL) begin
            op_dec = OP_BIT_TGL;
        end else begin
            // Other instructions belong to other units
            op_dec = OP_NONE;
        end
        next_two_word = (prog_data[15:12] == OPC_TWO_WORD_MOVE) ||
                        (prog_data[15:10] == OPC_TWO_WORD_LONG);
    end

    //==================================================================
    // Branch and skip decisions
    always_comb begin
        if (op_reg == OP_BR_ALWAYS) begin
            br_off = {{9{instr_reg[10]}}, instr_reg[10:0], 1'b0};
        end else begin
            br_off = {{12{instr_reg[7]}}, instr_reg[7:0], 1'b0};
        end
        br_target = pc_reg + br_off;
        unique case (op_reg)
            OP_BR_NO_OVF: take = !flag_ov;
            OP_BR_NOT_ZERO: take = !flag_z;
            OP_BR_ON_OVF: take = flag_ov;
            OP_BR_NOT_NEG: take = !flag_n;
            OP_BR_ALWAYS: take = 1'b1;
            default: take = 1'b0;
        endcase
        skip = (op_reg == OP_SKIP_CLR && !bit_val) ||
               (op_reg == OP_SKIP_SET && bit_val);
    end

    //==================================================================
    // Instruction sequencer
    always_comb begin
        qph_next = qph_reg;
        op_next = op_reg;
        instr_next = instr_reg;
        pc_next = pc_reg;
        rd_next = rd_reg;
        flush_next = flush_reg;
        flush_adv_next = flush_adv_reg;
        dmem_next = '0;
        dmem_next.addr = mem_addr;
        if (run) begin
            unique case (qph_reg)
                QPH_1: begin
                    qph_next = QPH_2;
                    if (flush_reg != 2'h0) begin
                        // Discarded slot: a no-operation runs in its place
                        op_next = OP_NONE;
                        if (flush_adv_reg) begin
                            pc_next = pc_reg + 21'h2;
                        end
                    end else begin
                        op_next = op_dec;
                        instr_next = prog_data;
                        pc_next = pc_reg + 21'h2;
                        dmem_next.re = (op_dec == OP_BIT_SET) || (op_dec == OP_BIT_TGL) ||
                                       (op_dec == OP_SKIP_CLR) || (op_dec == OP_SKIP_SET);
                    end
                end
                QPH_2: begin
                    qph_next = QPH_3;
                    rd_next = dmem_rdata;
                end
                QPH_3: begin
                    qph_next = QPH_4;
                    if (op_reg == OP_BIT_SET || op_reg == OP_BIT_TGL) begin
                        dmem_next.we = 1'b1;
                        dmem_next.wdata = bit_result;
                    end
                end
                QPH_4: begin
                    qph_next = QPH_1;
                    if (flush_reg != 2'h0) begin
                        flush_next = flush_reg - 2'h1;
                    end else if (take) begin
                        pc_next = br_target;
                        flush_next = FLUSH_ONE;
                        flush_adv_next = 1'b0;
                    end else if (skip) begin
                        // Skipped words are stepped over, not executed
                        flush_next = next_two_word ? FLUSH_TWO : FLUSH_ONE;
                        flush_adv_next = 1'b1;
                    end
                end
            endcase
        end
        if (wr_en && wb_adr_i == REG_PC) begin
            // Software reload of the program counter wins and cancels a flush
            pc_next = (pc_reg & ~wr_mask[20:0]) | (wb_dat_i[20:0] & wr_mask[20:0]);
            flush_next = 2'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qph_reg <= QPH_1;
            op_reg <= OP_NONE;
            instr_reg <= 16'h0000;
            pc_reg <= PC_RST;
            rd_reg <= 8'h00;
            flush_reg <= 2'h0;
            flush_adv_reg <= 1'b0;
            dmem_reg <= '0;
        end else begin
            qph_reg <= qph_next;
            op_reg <= op_next;
            instr_reg <= instr_next;
            pc_reg <= pc_next;
            rd_reg <= rd_next;
            flush_reg <= flush_next;
            flush_adv_reg <= flush_adv_next;
            dmem_reg <= dmem_next;
        end
    end

    //==================================================================
    // Wishbone register file
    always_comb begin
        wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
        wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        unique case (wb_adr_i)
            REG_CTRL: rd_mux = {30'h0, ctrl_reg};
            REG_STATUS: rd_mux = {27'h0, status_reg};
            REG_BANK_SEL: rd_mux = {28'h0, bank_reg};
            REG_PC: rd_mux = {11'h0, pc_reg};
            REG_FSR2: rd_mux = {20'h0, fsr2_reg};
            REG_STATE: rd_mux = {24'h0, op_reg, flush_reg, qph_reg};
            REG_INSTR: rd_mux = {16'h0, instr_reg};
            default: rd_mux = 32'h0;
        endcase
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        dat_next = ack_next ? rd_mux : 32'h0;
        ctrl_next = ctrl_reg;
        status_next = status_reg;
        bank_next = bank_reg;
        fsr2_next = fsr2_reg;
        if (wr_en) begin
            unique case (wb_adr_i)
                REG_CTRL: ctrl_next = (ctrl_reg & ~wr_mask[1:0]) | (wb_dat_i[1:0] & wr_mask[1:0]);
                REG_STATUS: begin
                    status_next = (status_reg & ~wr_mask[4:0]) | (wb_dat_i[4:0] & wr_mask[4:0]);
                end
                REG_BANK_SEL: bank_next = (bank_reg & ~wr_mask[3:0]) | (wb_dat_i[3:0] & wr_mask[3:0]);
                REG_FSR2: begin
                    fsr2_next = (fsr2_reg & ~wr_mask[11:0]) | (wb_dat_i[11:0] & wr_mask[11:0]);
                end
                default: ctrl_next = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
            status_reg <= STATUS_RST;
            bank_reg <= BANK_SEL_RST;
            fsr2_reg <= FSR2_RST;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            bank_reg <= bank_next;
            fsr2_reg <= fsr2_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    //==================================================================
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic pc_sw_wr;
    assign pc_sw_wr = wr_en && wb_adr_i == REG_PC;

    AST_NO_OVF_TAKEN: assert property (
        (qph_reg == QPH_4 && op_reg == OP_BR_NO_OVF && flush_reg == 2'h0 && !flag_ov &&
         !pc_sw_wr && run)
        |=> pc_reg == $past(pc_reg) + $past(br_off))
        else $error("overflow-clear branch did not load the target");

    AST_NOT_ZERO_HELD: assert property (
        (qph_reg == QPH_4 && op_reg == OP_BR_NOT_ZERO && flag_z && !pc_sw_wr)
        |=> $stable(pc_reg) && flush_reg == $past(flush_reg))
        else $error("not-zero branch moved the program counter with zero set");

    AST_ON_OVF_TAKEN: assert property (
        (qph_reg == QPH_4 && op_reg == OP_BR_ON_OVF && flush_reg == 2'h0 && flag_ov &&
         !pc_sw_wr && run)
        |=> pc_reg == $past(br_target))
        else $error("overflow-set branch did not load the target");

    AST_TAKEN_IDLE_CYCLE: assert property (
        (qph_reg == QPH_4 && take && flush_reg == 2'h0 && !pc_sw_wr && run)
        |=> (flush_reg == FLUSH_ONE && !flush_adv_reg)[*4] ##1 (flush_reg == 2'h0 || !run))
        else $error("taken branch not followed by exactly one idle cycle");

    AST_ALWAYS_FLAGS: assert property (
        (qph_reg == QPH_4 && op_reg == OP_BR_ALWAYS && flush_reg == 2'h0 && !wr_en && run)
        |=> pc_reg == $past(br_target) && $stable(status_reg) && flush_reg == FLUSH_ONE)
        else $error("unconditional branch wrong target or touched flags");

    AST_BIT_SET_WRITE: assert property (
        (qph_reg == QPH_4 && $past(qph_reg) == QPH_3 && op_reg == OP_BIT_SET)
        |-> dmem_reg.we && dmem_reg.wdata == (rd_reg | (8'h01 << instr_reg[11:9])))
        else $error("bit set wrote the wrong byte");

    AST_SKIP_CLR: assert property (
        (qph_reg == QPH_4 && op_reg == OP_SKIP_CLR && flush_reg == 2'h0 && !pc_sw_wr &&
         !rd_reg[instr_reg[11:9]] && run)
        |=> flush_reg != 2'h0 && flush_adv_reg)
        else $error("skip-if-clear did not skip on a clear bit");

    AST_SKIP_SET_TWO_WORD: assert property (
        (qph_reg == QPH_4 && op_reg == OP_SKIP_SET && flush_reg == 2'h0 && !pc_sw_wr &&
         rd_reg[instr_reg[11:9]] && next_two_word && run)
        |=> flush_reg == FLUSH_TWO)
        else $error("skip over a two-word instruction not two idle cycles");

    AST_BIT_TGL_WRITE: assert property (
        (qph_reg == QPH_4 && $past(qph_reg) == QPH_3 && op_reg == OP_BIT_TGL)
        |-> dmem_reg.we && dmem_reg.wdata == (rd_reg ^ (8'h01 << instr_reg[11:9])) &&
            $stable(status_reg))
        else $error("bit toggle wrote the wrong byte");

    AST_BANKED_ADDR: assert property (
        (qph_reg == QPH_2 && dmem_reg.re && instr_reg[8])
        |-> dmem_reg.addr == {$past(bank_reg), instr_reg[7:0]})
        else $error("banked access did not use the bank select register");

endmodule

/* File: bench/bbx_mem_model.sv */
module bbx_mem_model
    import bbx_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Program memory
    input wire logic [20:0] prog_addr,
    output logic [15:0] prog_data,
    // Data memory
    input wire bbx_dmem_req_s dmem_req,
    output logic [7:0] dmem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] pmem [256];
    logic [7:0] dmem [4096];

    //==================================================================
    // Program store
    // Aliases every 512 bytes; each test keeps its code in one window
    assign prog_data = pmem[prog_addr[8:1]];

    //==================================================================
    // Data store
    // Junk unless a read is strobed, so a late sample cannot pass
    always_comb begin
        dmem_rdata = dmem[dmem_req.addr];
        if (dmem_req.re !== 1'b1) begin
            dmem_rdata = ~dmem_rdata;
        end
    end

    always @(posedge sys_clk) begin
        if (dmem_req.we === 1'b1) begin
            dmem[dmem_req.addr] <= dmem_req.wdata;
        end
    end
endmodule

/* File: bench/branch_and_bit_instr_exec_tb.sv */
module branch_and_bit_instr_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bbx_pkg::*;

    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, dmem_rdata;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [20:0] prog_addr;
    logic [15:0] prog_data;
    bbx_dmem_req_s dmem_req;
    int n_fail = 0;
    int checked = 0;

    bbx_exec u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata));
    bbx_mem_model u_mem (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    //==================================================================
    // Common tasks
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic bail(input string msg);
        n_fail++;
        $display("[FAIL] %0t timeout in %s", $time, msg);
        test_done();
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Holds the request until ack is sampled, then releases it
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
        int i;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 20) bail("bus");
    endtask

    // Fresh reset, context, then run; returns just after the first fetch
    task automatic start(input logic [20:0] p, input logic [4:0] st, input logic [3:0] bank,
                         input logic [11:0] base, input logic ext);
        logic [31:0] rd;
        int i;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wb(1'b1, REG_STATUS, {27'h0, st}, rd);
        wb(1'b1, REG_BANK_SEL, {28'h0, bank}, rd);
        wb(1'b1, REG_FSR2, {20'h0, base}, rd);
        wb(1'b1, REG_PC, {11'h0, p}, rd);
        wb(1'b1, REG_CTRL, {30'h0, ext, 1'b1}, rd);
        for (i = 0; i < 20 && prog_addr === p; i++) step(1);
        if (prog_addr === p) bail("fetch");
    endtask

    //==================================================================
    // Scenarios
    task automatic t_regs();
        logic [31:0] rd;
        logic [7:0] adrs [6];
        int i;
        adrs = '{REG_CTRL, REG_STATUS, REG_BANK_SEL, REG_PC, REG_FSR2, 8'h1C};
        for (i = 0; i < 6; i++) begin
            wb(1'b0, adrs[i], 32'h0, rd);
            chk(rd, 32'h0, "reset value");
        end
        wb(1'b1, REG_PC, 32'hFFFFFFFF, rd);
        wb(1'b0, REG_PC, 32'h0, rd);
        chk(rd, 32'h001FFFFF, "pc width");
        wb_sel_i <= 4'h1;
        wb(1'b1, REG_PC, 32'h0, rd);
        wb_sel_i <= 4'hF;
        wb(1'b0, REG_PC, 32'h0, rd);
        chk(rd, 32'h001FFF00, "lane mask");
        wb(1'b1, 8'h1C, 32'hFFFFFFFF, rd);
        wb(1'b0, 8'h1C, 32'h0, rd);
        chk(rd, 32'h0, "unmapped");
        $display("t_regs done");
    endtask

    task automatic t_branches();
        logic [7:0] opc [4];
        int bitn [4];
        logic [3:0] tws;
        logic [4:0] mask;
        logic [7:0] n;
        logic [20:0] p, tgt;
        logic set, take;
        int i;
        opc = '{OPC_BR_NO_OVF, OPC_BR_NOT_ZERO, OPC_BR_ON_OVF, OPC_BR_NOT_NEG};
        bitn = '{STATUS_OV_BIT, STATUS_Z_BIT, STATUS_OV_BIT, STATUS_N_BIT};
        tws = 4'b0100;
        p = 21'h000100;
        for (i = 0; i < 8; i++) begin
            set = i[0];
            mask = 5'h01 << bitn[i / 2];
            take = (set == tws[i / 2]);
            n = set ? 8'h80 : 8'h7F;
            tgt = take ? p + 21'h2 + {{12{n[7]}}, n, 1'b0} : p + 21'h4;
            u_mem.pmem[p[8:1]] = {opc[i / 2], n};
            u_mem.pmem[p[8:1] + 8'h1] = 16'h0000;
            // Other flags opposite, so a wrong flag choice shows
            start(p, set ? mask : (5'h1C & ~mask), 4'h0, 12'h000, 1'b0);
            step(3);
            chk(prog_addr, take ? tgt : p + 21'h2, "branch pc");
            step(4);
            chk(prog_addr, tgt, "after branch");
        end
        $display("t_branches done");
    endtask

    task automatic t_bra();
        logic [10:0] offs [3];
        logic [20:0] p, tgt;
        logic [31:0] rd;
        int i;
        offs = '{11'h400, 11'h3FF, 11'h001};
        p = 21'h001000;
        for (i = 0; i < 3; i++) begin
            tgt = p + 21'h2 + {{9{offs[i][10]}}, offs[i], 1'b0};
            u_mem.pmem[p[8:1]] = {OPC_BR_ALWAYS, offs[i]};
            start(p, 5'h1C, 4'h0, 12'h000, 1'b0);
            step(3);
            chk(prog_addr, tgt, "always target");
            step(4);
            chk(prog_addr, tgt, "always idle");
            wb(1'b0, REG_STATUS, 32'h0, rd);
            chk(rd, 32'h1C, "flags kept");
        end
        $display("t_bra done");
    endtask

    task automatic t_bit(input logic [3:0] opc, input logic [2:0] b, input logic a,
                         input logic [7:0] f, input logic ext, input logic [3:0] bank);
        logic [11:0] ea;
        logic [7:0] m, d, exp;
        m = 8'h01 << b;
        ea = a ? {bank, f} : (f < ACCESS_SPLIT) ?
            (ext ? 12'h300 + {4'h0, f} : {ACCESS_LOW_BANK, f}) : {ACCESS_HIGH_BANK, f};
        d = (opc == OPC_BIT_SET) ? ~m : 8'hA5;
        exp = (opc == OPC_BIT_SET) ? (d | m) : (d ^ m);
        u_mem.dmem[ea] = d;
        u_mem.pmem[8'h20] = {opc, b, a, f};
        u_mem.pmem[8'h21] = 16'h0000;
        start(21'h000040, 5'h0A, bank, 12'h300, ext);
        chk(dmem_req.re, 1'b1, "read strobe");
        chk(dmem_req.addr, ea, "bit address");
        step(2);
        chk(dmem_req.we, 1'b1, "write strobe");
        chk(dmem_req.wdata, exp, "write data");
        step(1);
        chk(dmem_req.we, 1'b0, "single write");
    endtask

    task automatic t_bits();
        t_bit(OPC_BIT_SET, 3'h7, 1'b1, 8'h23, 1'b0, 4'h5);
        t_bit(OPC_BIT_TGL, 3'h0, 1'b0, 8'h5F, 1'b1, 4'h0);
        t_bit(OPC_BIT_SET, 3'h3, 1'b0, 8'h60, 1'b1, 4'h0);
        t_bit(OPC_BIT_TGL, 3'h4, 1'b0, 8'h10, 1'b0, 4'h0);
        t_bit(OPC_BIT_TGL, 3'h6, 1'b1, 8'hFF, 1'b0, 4'hF);
        $display("t_bits done");
    endtask

    // A relative jump follows the test; it only lands if it was not skipped
    task automatic t_skip(input logic [3:0] opc, input logic [2:0] b, input logic bv,
                          input logic two);
        logic [20:0] p;
        logic [7:0] m;
        logic skip;
        p = 21'h000080;
        m = 8'h01 << b;
        skip = (opc == OPC_SKIP_SET) ? bv : !bv;
        u_mem.dmem[12'h030] = bv ? m : ~m;
        u_mem.pmem[8'h40] = {opc, b, 1'b0, 8'h30};
        u_mem.pmem[8'h41] = !two ? {OPC_BR_ALWAYS, 11'h003} : (b == 3'h5) ?
            {OPC_TWO_WORD_LONG, 10'h000} : {OPC_TWO_WORD_MOVE, 12'h000};
        u_mem.pmem[8'h42] = two ? {OPC_BR_ALWAYS, 11'h003} : 16'h0000;
        u_mem.pmem[8'h43] = 16'h0000;
        start(p, 5'h00, 4'h0, 12'h000, 1'b0);
        step(11);
        chk(prog_addr, skip ? p + 21'h6 : p + (two ? 21'hC : 21'hA), "skip pc");
    endtask

    task automatic t_skips();
        t_skip(OPC_SKIP_CLR, 3'h0, 1'b0, 1'b0);
        t_skip(OPC_SKIP_CLR, 3'h7, 1'b1, 1'b0);
        t_skip(OPC_SKIP_SET, 3'h5, 1'b1, 1'b1);
        t_skip(OPC_SKIP_SET, 3'h2, 1'b0, 1'b1);
        t_skip(OPC_SKIP_CLR, 3'h1, 1'b0, 1'b1);
        t_skip(OPC_SKIP_SET, 3'h6, 1'b1, 1'b0);
        $display("t_skips done");
    endtask

    //==================================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        for (int i = 0; i < 256; i++) u_mem.pmem[i] = 16'h0000;
        for (int i = 0; i < 4096; i++) u_mem.dmem[i] = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_branches();
        t_bra();
        t_bits();
        t_skips();
        test_done();
    end
endmodule
